// ==== hw/hsw_health_word.sv ====
// health status word builder with over-range restart and turn detection
`timescale 1ns/1ps
module hsw_health_word (
  input  wire logic                       clk,
  input  wire logic                       rst,
  // host configuration load
  input  wire logic                       cfg_wr,
  input  wire hsw_pkg::hsw_cfg_t          cfg_in,
  output hsw_pkg::hsw_cfg_t               cfg_q,
  // error sources, levels
  input  wire logic                       fatal_err,
  input  wire logic                       hw_err,
  input  wire logic                       link_err,
  input  wire logic                       sw_err,
  // alert sources, levels, and the init completion pulse
  input  wire logic                       hw_warn,
  input  wire logic                       gnss_present,
  input  wire logic                       rate_flag_a,
  input  wire logic                       init_done,
  // low-passed rate sensor signals, z is yaw
  input  wire logic signed [15:0]         rate_lp_x,
  input  wire logic signed [15:0]         rate_lp_y,
  input  wire logic signed [15:0]         rate_lp_z,
  // packet build and diagnostic fetch
  input  wire logic                       pkt_build,
  input  wire logic                       fetch_packet_cmd,
  output hsw_pkg::hsw_word_t              health_word_q,
  output logic                            health_valid_q,
  output hsw_pkg::hsw_diag_t              diagnostic_packet_q,
  output logic                            diag_valid_q,
  // filter control
  output hsw_pkg::hsw_gain_t              gain_sel,
  output logic                            algo_restart_q,
  output logic                            turn_active
);

  // magnitude of a signed rate, saturating the most negative code
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    logic [15:0] r;
    r = v[15] ? 16'(-v) : 16'(v);
    if (r[15]) begin
      r = 16'h7fff;
    end
    return r;
  endfunction

  hsw_pkg::hsw_state_t state_q;
  hsw_pkg::hsw_state_t state_d;
  logic                quasi_static;
  logic                algo_flag;
  logic                fatal_now;
  logic [3:0]          raw_alerts;
  logic [3:0]          gated_alerts;
  hsw_pkg::hsw_word_t  word_now;
  logic [7:0]          ovr_cnt_q;
  logic                ovr_d1_q;

  // configuration register, defaults applied at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= hsw_pkg::CFG_RST;
    end else if (cfg_wr) begin
      cfg_q <= cfg_in;
    end
  end

  // quasi-static means every low-passed rate is strictly under the limit
  assign quasi_static = (mag16(rate_lp_x) < hsw_pkg::QS_LIMIT) &&
                        (mag16(rate_lp_y) < hsw_pkg::QS_LIMIT) &&
                        (mag16(rate_lp_z) < hsw_pkg::QS_LIMIT);

  // yaw turn detection; zero threshold flags a turn at any nonzero yaw
  assign turn_active = mag16(rate_lp_z) > cfg_q.turn_threshold;

  // algorithm phase tracking
  always_comb begin
    state_d = state_q;
    case (state_q)
      hsw_pkg::ST_INIT: begin
        if (rate_flag_a && cfg_q.restart_after_flag_a) begin
          state_d = hsw_pkg::ST_HOLD;
        end else if (init_done) begin
          state_d = hsw_pkg::ST_RUN;
        end
      end
      hsw_pkg::ST_RUN: begin
        // with the switch off an over-range leaves the phase alone
        if (rate_flag_a && cfg_q.restart_after_flag_a) begin
          state_d = hsw_pkg::ST_HOLD;
        end
      end
      hsw_pkg::ST_HOLD: begin
        if (!rate_flag_a && quasi_static) begin
          state_d = hsw_pkg::ST_INIT;
        end
      end
      default: begin
        state_d = hsw_pkg::ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= hsw_pkg::ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // one-cycle restart request to the filter on leaving the hold phase
  always_ff @(posedge clk) begin
    if (rst) begin
      algo_restart_q <= 1'b0;
    end else begin
      algo_restart_q <= (state_q == hsw_pkg::ST_HOLD) &&
                        (state_d == hsw_pkg::ST_INIT);
    end
  end

  // gain request: hold/init and dynamic-off force high gain, which
  // outranks the turn reduction since the estimate is not yet settled
  always_comb begin
    if (state_q != hsw_pkg::ST_RUN || !cfg_q.dynamic_motion) begin
      gain_sel = hsw_pkg::GAIN_HIGH;
    end else if (turn_active) begin
      gain_sel = hsw_pkg::GAIN_REDUCED;
    end else begin
      gain_sel = hsw_pkg::GAIN_NORMAL;
    end
  end

  // software alert: init, high gain, or turn when configured
  assign algo_flag = (gain_sel == hsw_pkg::GAIN_HIGH) ||
                     (cfg_q.turn_algo_en && turn_active);

  // fatal: external fatal source or restart hold
  assign fatal_now = fatal_err || (state_q == hsw_pkg::ST_HOLD);

  // alerts indexed by enable position
  assign raw_alerts[hsw_pkg::EN_HW]    = hw_warn;
  assign raw_alerts[hsw_pkg::EN_GNSS]  = !gnss_present;
  assign raw_alerts[hsw_pkg::EN_ALGO]  = algo_flag;
  assign raw_alerts[hsw_pkg::EN_RANGE] = rate_flag_a;
  assign gated_alerts = raw_alerts & cfg_q.alert_en;

  // word as it stands this cycle
  always_comb begin
    word_now                 = '0;
    word_now.fatal_flag      = fatal_now;
    word_now.hw_fault_flag   = hw_err;
    word_now.link_fault_flag = link_err;
    word_now.sw_fault_flag   = sw_err;
    word_now.alert_summary   = |gated_alerts;
    word_now.hw_alert        = gated_alerts[hsw_pkg::EN_HW];
    word_now.gnss_link_alert = gated_alerts[hsw_pkg::EN_GNSS];
    word_now.algo_alert      = gated_alerts[hsw_pkg::EN_ALGO];
    word_now.range_alert     = gated_alerts[hsw_pkg::EN_RANGE];
  end

  // word snapshot at each packet build instant
  always_ff @(posedge clk) begin
    if (rst) begin
      health_word_q  <= '0;
      health_valid_q <= 1'b0;
    end else begin
      health_valid_q <= pkt_build;
      if (pkt_build) begin
        health_word_q <= word_now;
      end
    end
  end

  // over-range event counter for diagnostics, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      ovr_d1_q  <= 1'b0;
      ovr_cnt_q <= '0;
    end else begin
      ovr_d1_q <= rate_flag_a;
      if (rate_flag_a && !ovr_d1_q &&
          ovr_cnt_q != hsw_pkg::OVR_CNT_MAX) begin
        ovr_cnt_q <= ovr_cnt_q + 8'h01;
      end
    end
  end

  // diagnostic packet capture on fetch command
  always_ff @(posedge clk) begin
    if (rst) begin
      diagnostic_packet_q <= '0;
      diag_valid_q        <= 1'b0;
    end else begin
      diag_valid_q <= fetch_packet_cmd;
      if (fetch_packet_cmd) begin
        diagnostic_packet_q.cfg              <= cfg_q;
        diagnostic_packet_q.state            <= state_q;
        diagnostic_packet_q.gain             <= gain_sel;
        diagnostic_packet_q.raw_errors       <=
          {sw_err, link_err, hw_err, fatal_err};
        diagnostic_packet_q.raw_alerts       <= raw_alerts;
        diagnostic_packet_q.turn_active      <= turn_active;
        diagnostic_packet_q.quasi_static     <= quasi_static;
        diagnostic_packet_q.flag_a_events <= ovr_cnt_q;
        diagnostic_packet_q.word             <= word_now;
      end
    end
  end

  // ------------------------------------------------------------------
  // checks kept next to the logic
  sequence s_build;
    pkt_build;
  endsequence

  sequence s_enter_hold;
    cfg_q.restart_after_flag_a && rate_flag_a &&
    state_q != hsw_pkg::ST_HOLD;
  endsequence

  sequence s_release;
    state_q == hsw_pkg::ST_HOLD && !rate_flag_a && quasi_static;
  endsequence

  a_word_valid: assert property (@(posedge clk) disable iff (rst)
    s_build |=> health_valid_q)
    else $error("health word not marked valid after build");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    health_word_q.reserved_lo == '0 && health_word_q.reserved_hi == '0)
    else $error("reserved health bits not zero");

  a_error_bits: assert property (@(posedge clk) disable iff (rst)
    s_build |=> health_word_q[hsw_pkg::BIT_HW_ERR] == $past(hw_err) &&
      health_word_q[hsw_pkg::BIT_LNK_ERR] == $past(link_err) &&
      health_word_q[hsw_pkg::BIT_SW_ERR] == $past(sw_err))
    else $error("error bits do not follow sources");

  a_summary_or: assert property (@(posedge clk) disable iff (rst)
    health_word_q[hsw_pkg::BIT_SUMMARY] ==
      |health_word_q[hsw_pkg::BIT_RANGE_AL:hsw_pkg::BIT_HW_AL])
    else $error("summary alert disagrees with alert bits");

  a_hw_default: assert property (@(posedge clk)
    rst |=> !cfg_q.alert_en[hsw_pkg::EN_HW] &&
      !cfg_q.restart_after_flag_a && cfg_q.dynamic_motion)
    else $error("configuration defaults wrong after reset");

  a_gnss_bit: assert property (@(posedge clk) disable iff (rst)
    s_build ##0 cfg_q.alert_en[hsw_pkg::EN_GNSS] |=>
      health_word_q[hsw_pkg::BIT_GNSS_AL] == !$past(gnss_present))
    else $error("satellite link alert wrong");

  a_no_restart_run: assert property (@(posedge clk) disable iff (rst)
    state_q == hsw_pkg::ST_RUN && !cfg_q.restart_after_flag_a |=>
      state_q == hsw_pkg::ST_RUN)
    else $error("over-range left run phase with switch off");

  a_hold_fatal: assert property (@(posedge clk) disable iff (rst)
    s_enter_hold ##1 s_build |=> health_word_q[hsw_pkg::BIT_FATAL])
    else $error("fatal flag missing during over-range hold");

  a_hold_stays: assert property (@(posedge clk) disable iff (rst)
    state_q == hsw_pkg::ST_HOLD && !quasi_static |=>
      state_q == hsw_pkg::ST_HOLD)
    else $error("hold left before quasi-static condition");

  // init_done may move the phase on one cycle after release, so the
  // phase is checked together with the pulse, not after it
  a_restart_pulse: assert property (@(posedge clk) disable iff (rst)
    s_release |=> algo_restart_q && state_q == hsw_pkg::ST_INIT ##1
      !algo_restart_q)
    else $error("restart pulse wrong after quasi-static");

  a_turn_gain: assert property (@(posedge clk) disable iff (rst)
    state_q == hsw_pkg::ST_RUN && cfg_q.dynamic_motion &&
      mag16(rate_lp_z) > cfg_q.turn_threshold |->
      gain_sel == hsw_pkg::GAIN_REDUCED)
    else $error("turn did not reduce gain");

  a_turn_alert: assert property (@(posedge clk) disable iff (rst)
    s_build ##0 turn_active && cfg_q.turn_algo_en &&
      cfg_q.alert_en[hsw_pkg::EN_ALGO] |=>
      health_word_q[hsw_pkg::BIT_ALGO_AL] &&
      health_word_q[hsw_pkg::BIT_SUMMARY])
    else $error("turn did not raise software alert");

  a_diag_fetch: assert property (@(posedge clk) disable iff (rst)
    fetch_packet_cmd |=> diag_valid_q &&
      diagnostic_packet_q.cfg == $past(cfg_q))
    else $error("diagnostic packet not returned");

  a_word_hold: assert property (@(posedge clk) disable iff (rst)
    !pkt_build |=> $stable(health_word_q))
    else $error("health word changed without a build");

  // fatal follows the external source and the restart hold alike
  a_fatal_bit: assert property (@(posedge clk) disable iff (rst)
    s_build |=> health_word_q[hsw_pkg::BIT_FATAL] ==
      ($past(fatal_err) || $past(state_q) == hsw_pkg::ST_HOLD))
    else $error("fatal flag does not follow fatal sources");

  a_range_bit: assert property (@(posedge clk) disable iff (rst)
    s_build ##0 cfg_q.alert_en[hsw_pkg::EN_RANGE] |=>
      health_word_q[hsw_pkg::BIT_RANGE_AL] == $past(rate_flag_a))
    else $error("over-range alert wrong");

  a_init_alert: assert property (@(posedge clk) disable iff (rst)
    s_build ##0 state_q != hsw_pkg::ST_RUN &&
      cfg_q.alert_en[hsw_pkg::EN_ALGO] |=>
      health_word_q[hsw_pkg::BIT_ALGO_AL])
    else $error("software alert missing outside run phase");

  a_dyn_gain: assert property (@(posedge clk) disable iff (rst)
    !cfg_q.dynamic_motion |-> gain_sel == hsw_pkg::GAIN_HIGH)
    else $error("dynamic motion off did not force high gain");

  a_cfg_load: assert property (@(posedge clk) disable iff (rst)
    cfg_wr |=> cfg_q == $past(cfg_in))
    else $error("configuration write not taken");

  // a restart outside the hold phase would reset a healthy filter
  a_restart_src: assert property (@(posedge clk) disable iff (rst)
    state_q != hsw_pkg::ST_HOLD |=> !algo_restart_q)
    else $error("restart pulse without hold phase");

  a_diag_word: assert property (@(posedge clk) disable iff (rst)
    fetch_packet_cmd |=> diagnostic_packet_q.word == $past(word_now) &&
      diagnostic_packet_q.flag_a_events == $past(ovr_cnt_q))
    else $error("diagnostic snapshot wrong");

endmodule

// ==== hw/hsw_pkg.sv ====
// shared types and constants for the health status word logic
package hsw_pkg;

  // rate scaling: low-passed rates arrive as signed counts, 64 counts per deg/s
  localparam int unsigned RATE_LSB_PER_DEG = 64;
  localparam int unsigned RATE_W           = 16;

  // quasi-static restart limit, deg/s
  localparam int unsigned QS_LIMIT_DEG = 3;
  localparam logic [RATE_W-1:0] QS_LIMIT =
    RATE_W'(QS_LIMIT_DEG * RATE_LSB_PER_DEG);

  // turn threshold default, tenths of deg/s (10.0 deg/s)
  localparam int unsigned TURN_DEFAULT_DECI = 100;
  localparam logic [RATE_W-1:0] TURN_DEFAULT =
    RATE_W'((TURN_DEFAULT_DECI * RATE_LSB_PER_DEG) / 10);

  // health word bit positions
  localparam int unsigned BIT_FATAL   = 0;
  localparam int unsigned BIT_HW_ERR  = 1;
  localparam int unsigned BIT_LNK_ERR = 2;
  localparam int unsigned BIT_SW_ERR  = 3;
  localparam int unsigned BIT_SUMMARY = 8;
  localparam int unsigned BIT_HW_AL   = 9;
  localparam int unsigned BIT_GNSS_AL = 10;
  localparam int unsigned BIT_ALGO_AL = 11;
  localparam int unsigned BIT_RANGE_AL = 12;

  // alert enable field: one bit per category, index = health bit - 9
  localparam int unsigned EN_HW    = 0;
  localparam int unsigned EN_GNSS  = 1;
  localparam int unsigned EN_ALGO  = 2;
  localparam int unsigned EN_RANGE = 3;
  // hardware alert disabled out of reset, the others enabled
  localparam logic [3:0] ALERT_EN_RST = 4'he;

  // health word layout, msb first (16 bits)
  typedef struct packed {
    logic [2:0] reserved_hi;
    logic       range_alert;
    logic       algo_alert;
    logic       gnss_link_alert;
    logic       hw_alert;
    logic       alert_summary;
    logic [3:0] reserved_lo;
    logic       sw_fault_flag;
    logic       link_fault_flag;
    logic       hw_fault_flag;
    logic       fatal_flag;
  } hsw_word_t;

  // host configuration
  typedef struct packed {
    logic [3:0]        alert_en;
    logic              restart_after_flag_a;
    logic              dynamic_motion;
    logic              turn_algo_en;
    logic [RATE_W-1:0] turn_threshold;
  } hsw_cfg_t;

  localparam hsw_cfg_t CFG_RST = '{
    alert_en:                ALERT_EN_RST,
    restart_after_flag_a: 1'b0,
    dynamic_motion:          1'b1,
    turn_algo_en:            1'b0,
    turn_threshold:          TURN_DEFAULT
  };

  // algorithm phase
  typedef enum logic [1:0] {
    ST_INIT,
    ST_RUN,
    ST_HOLD
  } hsw_state_t;

  // accelerometer feedback gain request to the filter
  typedef enum logic [1:0] {
    GAIN_NORMAL,
    GAIN_HIGH,
    GAIN_REDUCED
  } hsw_gain_t;

  // diagnostic packet payload: full subsystem status
  typedef struct packed {
    hsw_cfg_t   cfg;
    hsw_state_t state;
    hsw_gain_t  gain;
    logic [3:0] raw_errors;
    logic [3:0] raw_alerts;
    logic       turn_active;
    logic       quasi_static;
    logic [7:0] flag_a_events;
    hsw_word_t  word;
  } hsw_diag_t;

  localparam logic [7:0] OVR_CNT_MAX = 8'hff;

endpackage

// ==== bench/hsw_host_model.sv ====
// host controller model: configures the block and polls packets
`timescale 1ns/1ps
module hsw_host_model (
  input  wire logic               clk,
  input  wire logic               health_valid_q,
  input  wire hsw_pkg::hsw_word_t health_word_q,
  input  wire logic               diag_valid_q,
  output logic                    pkt_build,
  output logic                    fetch_packet_cmd,
  output logic                    cfg_wr,
  output hsw_pkg::hsw_cfg_t       cfg_in
);
  // idle until the bench asks for something
  initial begin
    pkt_build = 1'b0;
    fetch_packet_cmd = 1'b0;
    cfg_wr = 1'b0;
    cfg_in = '0;
  end

  // host picks the alert categories and switches in one write
  task automatic put_cfg(input hsw_pkg::hsw_cfg_t c);
    @(posedge clk);
    cfg_in <= c;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask

  // one packet build, word captured with its valid pulse
  task automatic get_word(output logic [15:0] w, output logic v);
    @(posedge clk);
    pkt_build <= 1'b1;
    @(posedge clk);
    pkt_build <= 1'b0;
    #1;
    v = health_valid_q;
    w = health_word_q;
  endtask

  // two builds back to back, valid seen on three cycles
  task automatic burst(output logic [2:0] v);
    @(posedge clk);
    pkt_build <= 1'b1;
    @(posedge clk);
    #1 v[0] = health_valid_q;
    @(posedge clk);
    pkt_build <= 1'b0;
    #1 v[1] = health_valid_q;
    @(posedge clk);
    #1 v[2] = health_valid_q;
  endtask

  // diagnostic fetch request
  task automatic fetch(output logic v);
    @(posedge clk);
    fetch_packet_cmd <= 1'b1;
    @(posedge clk);
    fetch_packet_cmd <= 1'b0;
    #1 v = diag_valid_q;
  endtask
endmodule

// ==== bench/hsw_health_word_tb_top.sv ====
// self-checking bench for the health word builder
`timescale 1ns/1ps
module hsw_health_word_tb_top;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [3:0]         err = 4'h0;
  logic               hw_warn = 1'b0;
  logic               gnss_present = 1'b1;
  logic               rate_flag_a = 1'b0;
  logic               init_done = 1'b0;
  logic signed [15:0] rate_lp_x = '0;
  logic signed [15:0] rate_lp_y = '0;
  logic signed [15:0] rate_lp_z = '0;
  logic               cfg_wr, pkt_build, fetch_packet_cmd;
  hsw_pkg::hsw_cfg_t  cfg_in, cfg_q, cfg_v;
  hsw_pkg::hsw_word_t health_word_q;
  hsw_pkg::hsw_diag_t diagnostic_packet_q;
  hsw_pkg::hsw_gain_t gain_sel;
  logic               health_valid_q, diag_valid_q;
  logic               algo_restart_q, turn_active;
  logic [15:0]        w;
  logic               v;
  logic [2:0]         v3;
  int                 fails = 0;
  int                 num_checks = 0;

  // 100 ns period
  always #50 clk = ~clk;

  hsw_health_word hsw_health_word_inst (
    .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_in(cfg_in), .cfg_q(cfg_q),
    .fatal_err(err[0]), .hw_err(err[1]), .link_err(err[2]),
    .sw_err(err[3]), .hw_warn(hw_warn), .gnss_present(gnss_present),
    .rate_flag_a(rate_flag_a), .init_done(init_done),
    .rate_lp_x(rate_lp_x), .rate_lp_y(rate_lp_y), .rate_lp_z(rate_lp_z),
    .pkt_build(pkt_build), .fetch_packet_cmd(fetch_packet_cmd),
    .health_word_q(health_word_q), .health_valid_q(health_valid_q),
    .diagnostic_packet_q(diagnostic_packet_q),
    .diag_valid_q(diag_valid_q), .gain_sel(gain_sel),
    .algo_restart_q(algo_restart_q), .turn_active(turn_active)
  );

  hsw_host_model hsw_host_model_inst (
    .clk(clk), .health_valid_q(health_valid_q),
    .health_word_q(health_word_q), .diag_valid_q(diag_valid_q),
    .pkt_build(pkt_build), .fetch_packet_cmd(fetch_packet_cmd),
    .cfg_wr(cfg_wr), .cfg_in(cfg_in)
  );

  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // closing verdict, the only exit of the run
  task automatic results;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // build a packet and compare the word it carries
  task automatic build(input logic [15:0] exp);
    hsw_host_model_inst.get_word(w, v);
    check(v, 1'b1);
    check(w, exp);
  endtask

  task automatic set_cfg;
    hsw_host_model_inst.put_cfg(cfg_v);
    tick(2);
  endtask

  // a pulse, since the filter reports init completion once
  task automatic finish_init;
    @(posedge clk) init_done <= 1'b1;
    @(posedge clk) init_done <= 1'b0;
    tick(2);
  endtask

  // hang guard, far beyond the 130 or so cycles the tests need
  initial begin
    #200000;
    fails++;
    results;
  end

  initial begin
    tick(8);
    rst <= 1'b0;
    @(posedge clk) #1;
    check(cfg_q, {4'he, 1'b0, 1'b1, 1'b0, 16'h0280});
    check(gain_sel, hsw_pkg::GAIN_HIGH);
    build(16'h0900);
    cfg_v = cfg_q;
    finish_init;
    build(16'h0000);
    // each error source lands on its own low-byte bit
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) err <= 4'h1 << i;
      tick(2);
      build(16'h0001 << i);
    end
    @(posedge clk) err <= 4'h0;
    hw_warn <= 1'b1;
    tick(2);
    build(16'h0000);
    cfg_v.alert_en = 4'hf;
    set_cfg;
    build(16'h0300);
    @(posedge clk) hw_warn <= 1'b0;
    gnss_present <= 1'b0;
    tick(2);
    build(16'h0500);
    cfg_v.alert_en = 4'h0;
    set_cfg;
    build(16'h0000);
    cfg_v.alert_en = 4'hf;
    set_cfg;
    // switch off: brief over-range is only flagged
    @(posedge clk) gnss_present <= 1'b1;
    rate_flag_a <= 1'b1;
    rate_lp_x <= 16'sd400;
    tick(3);
    build(16'h1100);
    check(gain_sel, hsw_pkg::GAIN_NORMAL);
    cfg_v.restart_after_flag_a = 1'b1;
    set_cfg;
    build(16'h1901);
    // 192 counts is exactly 3 deg/s, still not quasi-static
    @(posedge clk) rate_flag_a <= 1'b0;
    rate_lp_x <= 16'sd192;
    tick(3);
    build(16'h0901);
    check(algo_restart_q, 1'b0);
    @(posedge clk) rate_lp_x <= 16'sd191;
    rate_lp_y <= -16'sd191;
    @(posedge clk) #1;
    check(algo_restart_q, 1'b1);
    @(posedge clk) #1;
    check(algo_restart_q, 1'b0);
    check(gain_sel, hsw_pkg::GAIN_HIGH);
    @(posedge clk) rate_lp_x <= '0;
    rate_lp_y <= '0;
    finish_init;
    build(16'h0000);
    cfg_v.dynamic_motion = 1'b0;
    set_cfg;
    check(gain_sel, hsw_pkg::GAIN_HIGH);
    build(16'h0900);
    cfg_v.dynamic_motion = 1'b1;
    set_cfg;
    // yaw right at the threshold does not count as a turn
    @(posedge clk) rate_lp_z <= 16'sd640;
    tick(2);
    check(turn_active, 1'b0);
    check(gain_sel, hsw_pkg::GAIN_NORMAL);
    @(posedge clk) rate_lp_z <= -16'sd641;
    tick(2);
    check(turn_active, 1'b1);
    check(gain_sel, hsw_pkg::GAIN_REDUCED);
    build(16'h0000);
    cfg_v.turn_algo_en = 1'b1;
    set_cfg;
    build(16'h0900);
    hsw_host_model_inst.fetch(v);
    check(v, 1'b1);
    check(diagnostic_packet_q.cfg, cfg_v);
    check(diagnostic_packet_q.word, 16'h0900);
    check(diagnostic_packet_q.gain, hsw_pkg::GAIN_REDUCED);
    check(diagnostic_packet_q.flag_a_events, 8'h01);
    @(posedge clk) #1;
    check(diag_valid_q, 1'b0);
    hsw_host_model_inst.burst(v3);
    check(v3, 3'b011);
    // second reset in mid-run restores the defaults
    @(posedge clk) rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    @(posedge clk) #1;
    check(cfg_q, {4'he, 1'b0, 1'b1, 1'b0, 16'h0280});
    check(health_word_q, 16'h0000);
    results;
  end
endmodule
